// file: utdh_pkg.sv
// constants and types for the transceiver data handshake block
package utdh_pkg;

  // ==========================================================
  // widths and depths
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int DEPTH = 2;

  // ==========================================================
  // reset values and the zero fill byte
  localparam logic RST_LOW = 1'b0;
  localparam logic RST_OE_N = 1'b1;
  localparam logic [1:0] RST_COUNT = 2'h0;
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ==========================================================
  // receive sequencing states
  typedef enum logic [1:0] {
    UTDH_IDLE = 2'b00,
    UTDH_RECV = 2'b01,
    UTDH_DRAIN = 2'b10
  } utdh_rx_st_t;

  // one word with its upper byte qualifier
  typedef struct packed {
    logic [15:0] data;
    logic hi;
  } utdh_word_t;

  // whole state of the core
  typedef struct packed {
    logic m16_s1;
    logic m16_s2;
    utdh_rx_st_t st;
    utdh_word_t [1:0] ent;
    logic wr;
    logic rd;
    logic [1:0] count;
    logic in_ready;
    utdh_word_t tx_hold;
    logic tx_full;
    logic txready;
    logic rxvalid;
    logic rxerror;
    logic rxactive;
    logic [15:0] dout;
    logic validh_out;
    logic oe_n_hi;
    logic oe_n_lo;
    logic validh_oe_n;
  } utdh_state_t;

endpackage

// file: utdh_core.sv
// data handshake core between transceiver receive/transmit engines and SIE
`timescale 1ns/1ps
module utdh_core (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic mode16_pin,
  input wire logic tx_valid,
  input wire logic [15:0] data_in,
  input wire logic validh_in,
  output logic [15:0] data_out,
  output logic data_oe_n_hi,
  output logic data_oe_n_lo,
  output logic validh_out,
  output logic validh_oe_n,
  output logic tx_ready,
  output logic rx_valid,
  output logic rx_active,
  output logic rx_error,
  input wire logic rx_in_valid,
  input wire utdh_pkg::utdh_word_t rx_in_word,
  output logic rx_in_ready,
  input wire logic rx_sop_active,
  input wire logic rx_err_in,
  output utdh_pkg::utdh_word_t tx_line_word,
  output logic tx_line_valid,
  input wire logic tx_line_ready
);

  // ==========================================================
  // state
  utdh_pkg::utdh_state_t s;
  utdh_pkg::utdh_state_t next_s;
  logic mode16;
  logic take;
  logic push;
  logic pop;
  utdh_pkg::utdh_word_t head;

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    mode16 = s.m16_s2;
    head = s.ent[s.rd];
    // mode strap through two flops
    next_s.m16_s1 = mode16_pin;
    next_s.m16_s2 = s.m16_s1;
    // transmit word taken on a ready edge
    take = tx_valid & s.txready;
    if (s.tx_full && tx_line_ready) begin
      next_s.tx_full = 1'b0;
    end
    if (take) begin
      next_s.tx_hold.data = mode16 ? data_in
                                   : {utdh_pkg::ZERO_BYTE, data_in[7:0]};
      next_s.tx_hold.hi = mode16 & validh_in;
      next_s.tx_full = 1'b1;
    end
    // receive buffer: pop blocked while the SIE owns the 16-bit bus
    push = rx_in_valid & s.in_ready;
    pop = (s.count != utdh_pkg::RST_COUNT) & (~mode16 | ~tx_valid);
    // no take in a cycle where the device drives the shared 16-bit bus
    next_s.txready = ~next_s.tx_full & ~(mode16 & pop);
    if (push) begin
      next_s.ent[s.wr] = rx_in_word;
      next_s.wr = ~s.wr;
    end
    next_s.rxvalid = pop;
    if (pop) begin
      next_s.rd = ~s.rd;
      next_s.dout = mode16 ? head.data
                           : {head.data[7:0], utdh_pkg::ZERO_BYTE};
      next_s.validh_out = mode16 & head.hi;
    end
    next_s.count = s.count + 2'(push) - 2'(pop);
    next_s.in_ready = next_s.count < 2'(utdh_pkg::DEPTH);
    // bus direction: upper lines always out in 8-bit mode
    next_s.oe_n_hi = ~(~mode16 | pop);
    next_s.oe_n_lo = ~(mode16 & pop);
    next_s.validh_oe_n = ~(mode16 & pop);
    // error registered one edge after rx_err_in, not through the data buffer
    next_s.rxerror = rx_err_in
                   & (rx_sop_active | s.st != utdh_pkg::UTDH_IDLE);
    // receive activity sequencing
    case (s.st)
      utdh_pkg::UTDH_IDLE: begin
        if (rx_sop_active) begin
          next_s.st = utdh_pkg::UTDH_RECV;
        end
      end
      utdh_pkg::UTDH_RECV: begin
        if (!rx_sop_active) begin
          next_s.st = utdh_pkg::UTDH_DRAIN;
        end
      end
      utdh_pkg::UTDH_DRAIN: begin
        if (rx_sop_active) begin
          next_s.st = utdh_pkg::UTDH_RECV;
        end else if (s.count == utdh_pkg::RST_COUNT) begin
          // leave only after the last word's valid cycle has passed
          next_s.st = utdh_pkg::UTDH_IDLE;
        end
      end
      default: begin
        next_s.st = utdh_pkg::UTDH_IDLE;
      end
    endcase
    // activity flag registered so the output leaves a flop
    next_s.rxactive = (next_s.st != utdh_pkg::UTDH_IDLE);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
      s.st <= utdh_pkg::UTDH_IDLE;
      s.count <= utdh_pkg::RST_COUNT;
      s.in_ready <= utdh_pkg::RST_LOW;
      s.txready <= utdh_pkg::RST_LOW;
      s.dout <= utdh_pkg::RST_DATA;
      s.oe_n_hi <= utdh_pkg::RST_OE_N;
      s.oe_n_lo <= utdh_pkg::RST_OE_N;
      s.validh_oe_n <= utdh_pkg::RST_OE_N;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign data_out = s.dout;
  assign data_oe_n_hi = s.oe_n_hi;
  assign data_oe_n_lo = s.oe_n_lo;
  assign validh_out = s.validh_out;
  assign validh_oe_n = s.validh_oe_n;
  assign tx_ready = s.txready;
  assign rx_valid = s.rxvalid;
  assign rx_active = s.rxactive;
  assign rx_error = s.rxerror;
  assign rx_in_ready = s.in_ready;
  assign tx_line_word = s.tx_hold;
  assign tx_line_valid = s.tx_full;

  // ==========================================================
  // checks
  property p_take_fills;
    @(posedge clk) disable iff (!rstn)
      (ce && tx_valid && tx_ready) |=> tx_line_valid;
  endproperty
  AST_TX_TAKE: assert property (p_take_fills)
    else $error("taken transmit word not held");

  AST_TX_READY_FREE: assert property (@(posedge clk) disable iff (!rstn)
    (ce && tx_ready) |-> !tx_line_valid)
    else $error("transmit ready while holding full");

  AST_DRIVE_16: assert property (@(posedge clk) disable iff (!rstn)
    (ce && $past(ce) && $past(mode16) && rx_valid)
      |-> (!data_oe_n_lo && !validh_oe_n))
    else $error("16-bit receive word not driven");

  AST_NO_DRIVE_TX: assert property (@(posedge clk) disable iff (!rstn)
    (ce && mode16 && tx_valid) |=> data_oe_n_lo)
    else $error("device drove bus during transmit");

  AST_VALIDH_FULL: assert property (@(posedge clk) disable iff (!rstn)
    (ce && mode16 && pop && head.hi) |=> validh_out)
    else $error("upper qualifier missing on full word");

  AST_VALIDH_LOW: assert property (@(posedge clk) disable iff (!rstn)
    (ce && pop && !(mode16 && head.hi)) |=> !validh_out)
    else $error("upper qualifier set on byte word");

  AST_BYTE_UPPER: assert property (@(posedge clk) disable iff (!rstn)
    (ce && !mode16 && pop) |=> (data_out[15:8] == $past(head.data[7:0])
      && !data_oe_n_hi))
    else $error("8-bit receive byte not on upper lines");

  AST_RXVALID_SRC: assert property (@(posedge clk) disable iff (!rstn)
    (ce && rx_valid) |-> $past(s.count) != 2'h0)
    else $error("receive valid with empty buffer");

  AST_ACTIVE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    (ce && rx_sop_active) |=> rx_active [*2])
    else $error("receive active dropped during packet");

  AST_ERR_TIME: assert property (@(posedge clk) disable iff (!rstn)
    (ce && rx_err_in && rx_sop_active) |=> rx_error)
    else $error("receive error not flagged");

  COV_RX16: cover property (@(posedge clk) mode16 && rx_valid && validh_out);
  COV_TX: cover property (@(posedge clk) tx_valid && tx_ready);
  COV_FULL: cover property (@(posedge clk) s.count == 2'h2 && tx_valid);
  COV_ERR: cover property (@(posedge clk) rx_error && rx_active);

endmodule

// file: utdh_sie_model.sv
// SIE-side model that offers transmit words to the core
`timescale 1ns/1ps
module utdh_sie_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic want,
  input wire utdh_pkg::utdh_word_t next_word,
  input wire logic tx_ready,
  output logic tx_valid,
  output utdh_pkg::utdh_word_t word
);
  // ==========================================
  // offer: word held until an edge with ready
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_valid <= 1'b0;
      word <= '0;
    end else if (!tx_valid || tx_ready) begin
      tx_valid <= want;
      word <= next_word;
    end
  end
endmodule

// file: test_utmi_data_handshake.sv
// self-checking bench for the data handshake core
`timescale 1ns/1ps
module test_utmi_data_handshake;
  logic clk = 0, rstn = 0, m16 = 1, want = 0, rxv = 0, sop = 0, err = 0;
  logic txlr = 0, pe = 0, oe_hi, oe_lo, vh_out, vh_oe, txr, rxval, rxact;
  logic rxerr, rxir, tlv, txv;
  logic [15:0] dout, mask;
  logic [31:0] seed = 32'h1a1028fe, r;
  int errors = 0, checks = 0;
  utdh_pkg::utdh_word_t nw = '0, rw = '0, sw, tw, e;
  utdh_pkg::utdh_word_t rq[$], tq[$];
  // resolved bus: pull-down where nobody drives
  wire [15:0] bus = {!oe_hi ? dout[15:8] : (txv && m16) ? sw.data[15:8] : 8'h00,
    !oe_lo ? dout[7:0] : txv ? sw.data[7:0] : 8'h00};
  wire vbus = !vh_oe ? vh_out : (txv && m16) ? sw.hi : 1'b0;

  always #50 clk = ~clk;

  utdh_core uut (.clk(clk), .rstn(rstn), .ce(1'b1), .mode16_pin(m16),
    .tx_valid(txv), .data_in(bus), .validh_in(vbus), .data_out(dout),
    .data_oe_n_hi(oe_hi), .data_oe_n_lo(oe_lo), .validh_out(vh_out),
    .validh_oe_n(vh_oe), .tx_ready(txr), .rx_valid(rxval), .rx_active(rxact),
    .rx_error(rxerr), .rx_in_valid(rxv), .rx_in_word(rw), .rx_in_ready(rxir),
    .rx_sop_active(sop), .rx_err_in(err), .tx_line_word(tw),
    .tx_line_valid(tlv), .tx_line_ready(txlr));

  utdh_sie_model sie (.clk(clk), .rstn(rstn), .want(want), .next_word(nw),
    .tx_ready(txr), .tx_valid(txv), .word(sw));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task end_of_test;
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================
  // reference model: queues of words in flight
  always @(posedge clk) begin
    if (rstn) begin
      chk("rx_error", {16'h0, pe}, {16'h0, rxerr});
      if (rxv && rxir)
        rq.push_back(rw);
      if (txv && txr)
        tq.push_back(m16 ? sw : {8'h00, sw.data[7:0], 1'b0});
      if (tlv && txlr)
        chk("tx_word", tq.pop_front(), tw);
      if (rxval) begin
        e = rq.pop_front();
        mask = e.hi ? 16'hffff : 16'h00ff;
        chk("rx_active", 17'h1, {16'h0, rxact});
        if (m16)
          chk("rx_word", {e.data & mask, e.hi}, {bus & mask, vbus});
        else
          chk("rx_byte", {9'h0, e.data[7:0]}, {9'h0, bus[15:8]});
      end
    end
    pe <= err;
  end

  // ==========================================
  // one random traffic phase in one bus mode
  task run(input logic m, input int n);
    m16 <= m;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      r = xs();
      sop <= 1'b1;
      rxv <= r[0];
      rw <= r[17:1];
      want <= m ? r[18] | r[19] : r[18];
      txlr <= r[20] | r[21];
      err <= (i > 1 && i < n - 1) ? r[22] & r[23] : 1'b0;
      nw <= r[31:15];
    end
    @(posedge clk);
    sop <= 1'b0;
    rxv <= 1'b0;
    want <= 1'b0;
    err <= 1'b0;
    txlr <= 1'b1;
    repeat (20) @(posedge clk);
    chk("idle", 17'h2, {14'h0, rxact, txr, tlv});
    chk("drained", 17'h0, 17'(rq.size() + tq.size()));
  endtask

  initial begin
    repeat (5) @(posedge clk);
    chk("reset", 17'he0, {9'h0, oe_hi, oe_lo, vh_oe, txr, rxir, rxval, tlv, rxact});
    @(posedge clk);
    rstn <= 1'b1;
    run(1'b1, 400);
    run(1'b0, 400);
    run(1'b1, 200);
    end_of_test;
  end

  // ==========================================
  // watchdog against a hung handshake
  initial begin
    #(3000 * 100);
    errors++;
    end_of_test;
  end
endmodule
